//--- dv/vdi2c_i2c_master.sv
/* i2c master model, signals moved on core clock edges.
   assumes the bench resolves a pulled-up sda wire. */
`timescale 1ns/100ps
module vdi2c_i2c_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  int q = 63;
  logic [7:0] obs;
  event obs_ev;
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  // ==========
  // one quarter bit; q sets the rate (63 near 400 kbit/s)
  task automatic ph(input logic s, input logic d);
    @(posedge clk);
    scl <= s;
    sda_m <= d;
    repeat (q - 1) @(posedge clk);
  endtask
  // data moves only while scl is low
  task automatic bit_x(input logic b, output logic r);
    ph(1'h0, sda_m);
    ph(1'h0, b);
    ph(1'h1, b);
    r = sda;
    ph(1'h1, b);
  endtask
  task automatic start_c();
    ph(1'h0, sda_m);
    ph(1'h0, 1'h1);
    ph(1'h1, 1'h1);
    ph(1'h1, 1'h0);
  endtask
  task automatic stop_c();
    ph(1'h0, sda_m);
    ph(1'h0, 1'h0);
    ph(1'h1, 1'h0);
    ph(1'h1, 1'h1);
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'h1, r);
    obs = {7'h00, r};
    ->obs_ev;
  endtask
  task automatic recv_byte(input logic nack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
    bit_x(nack, r);
    obs = d;
    ->obs_ev;
  endtask
endmodule // vdi2c_i2c_master

//--- dv/vdi2c_slave_checker.sv
/* checker of the i2c slave port pins and stored bytes.
   assumes it is bound onto vdi2c_slave. */
`timescale 1ns/100ps
module vdi2c_slave_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [vdi2c_pkg::REG_BYTES*8-1:0] cfg_bytes
);
  // ==========
  // bus side
  a_sda_out_low: assert property (@(posedge link_clk) disable iff (rst)
    sda_out == 1'h0) else $error("sda_out not held low");
  a_oe_moves_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2)) else $error("sda_oe moved near scl high");
  a_oe_holds_high: assert property (@(posedge link_clk) disable iff (rst)
    $rose(scl_in) && sda_oe |=> sda_oe [*8]) else $error("sda_oe dropped while scl high");
  a_frame_by_master: assert property (@(posedge link_clk) disable iff (rst)
    scl_in && $past(scl_in) && $changed(sda_in) |-> !sda_oe && !$past(sda_oe))
    else $error("slave disturbed start or stop");
  // ==========
  // stored bytes; read-only places must never hold a value
  a_cfg_reset_zero: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> cfg_bytes == '0) else $error("cfg not zero after reset");
  a_version_place: assert property (@(posedge core_clk) disable iff (rst)
    cfg_bytes[7:0] == 8'h00) else $error("version place stored a value");
  a_status_not_kept: assert property (@(posedge core_clk) disable iff (rst)
    cfg_bytes[255:248] == 8'h00) else $error("status place stored a value");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    cfg_bytes[167:160] == 8'h00 && cfg_bytes[247:192] == '0 && cfg_bytes[511:256] == '0)
    else $error("reserved place stored a value");
endmodule // vdi2c_slave_checker

bind vdi2c_slave vdi2c_slave_checker i_chk (.core_clk(core_clk), .rst(rst),
  .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .cfg_bytes(cfg_bytes));

//--- dv/vdi2c_slave_tb.sv
/* self-checking bench of the video decoder i2c slave port.
   assumes the master model drives the bus; sda has a pull-up. */
`timescale 1ns/100ps
module vdi2c_slave_tb;
  import vdi2c_pkg::*;
  localparam logic [3:0] VER = 4'hA; // arbitrary value
  localparam logic [7:0] VER_BYTE = {VER, VERSION_LOW_NIBBLE};
  logic core_clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic strap = 1'h1;
  logic [7:0] st = 8'h00, dr = 8'h00, ln1 = 8'h00, ln2 = 8'h00;
  logic sda_oe, sda_out, scl, sda_m, sda_w;
  logic [REG_BYTES*8-1:0] cfg;
  logic [7:0] exp_q[$], da[$], db[$];
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  assign sda_w = sda_m & ~(sda_oe & ~sda_out);

  vdi2c_slave #(.CHIP_VERSION(VER)) i_vdi2c_slave (.core_clk(core_clk), .rst(rst),
    .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_pin(strap), .status_byte(st), .slicer_status_dr(dr),
    .slicer_status_ln1(ln1), .slicer_status_ln2(ln2), .cfg_bytes(cfg));
  vdi2c_i2c_master i_vdi2c_i2c_master (.clk(core_clk), .sda(sda_w), .scl(scl),
    .sda_m(sda_m));

  // ==========
  // compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(i_vdi2c_i2c_master.obs_ev) begin
    chk(i_vdi2c_i2c_master.obs, exp_q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    // scenarios need about 93200 cycles; a hang must still end under 100k
    if (cyc == 99000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========
  // transfers; ack expected as 00, nack as 01
  task automatic put(input logic [7:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    i_vdi2c_i2c_master.send_byte(b);
  endtask
  task automatic get(input logic n, input logic [7:0] e);
    exp_q.push_back(e);
    i_vdi2c_i2c_master.recv_byte(n);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d[$]);
    i_vdi2c_i2c_master.start_c();
    put(a, 8'h00);
    put(s, 8'h00);
    foreach (d[i]) put(d[i], 8'h00);
    i_vdi2c_i2c_master.stop_c();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] s, input logic [7:0] e[$]);
    i_vdi2c_i2c_master.start_c();
    put(a & 8'hFE, 8'h00);
    put(s, 8'h00);
    i_vdi2c_i2c_master.start_c();
    put(a, 8'h00);
    foreach (e[i]) get(i == e.size() - 1, e[i]);
    i_vdi2c_i2c_master.stop_c();
  endtask
  task automatic cfg_chk(input int s, input logic [7:0] e[$]);
    foreach (e[i]) chk(cfg[(s + i) * 8 +: 8], e[i]);
  endtask

  initial begin
    void'($urandom(32'h9e6d));
    for (int i = 0; i < 3; i++) da.push_back(8'($urandom()));
    for (int i = 0; i < 3; i++) db.push_back(8'($urandom()));
    @(posedge core_clk);
    st <= 8'($urandom());
    dr <= 8'($urandom());
    ln1 <= 8'($urandom());
    ln2 <= 8'($urandom());
    repeat (9) @(posedge core_clk);
    rst <= 1'h0;
    repeat (20) @(posedge core_clk);
    wr(8'h4A, 8'h04, da);
    cfg_chk(8'h04, da);
    rd(8'h4B, 8'h04, da);
    wr(8'h4A, 8'h13, db);
    cfg_chk(8'h13, {db[0], 8'h00, db[2]});
    rd(8'h4B, 8'h1F, {st, 8'h00});
    rd(8'h4B, 8'h60, {dr, ln1});
    // strap low: old address must go unanswered
    strap <= 1'h0;
    i_vdi2c_i2c_master.start_c();
    put(8'h4A, 8'h01);
    i_vdi2c_i2c_master.stop_c();
    rd(8'h49, 8'h00, {VER_BYTE});
    // standard rate costs four times the cycles: address and ack only
    i_vdi2c_i2c_master.q = 250;
    i_vdi2c_i2c_master.start_c();
    put(8'h48, 8'h00);
    i_vdi2c_i2c_master.stop_c();
    i_vdi2c_i2c_master.q = 63;
    wr(8'h48, 8'h60, {db[1]});
    cfg_chk(8'h60, {db[1]});
    give_verdict();
  end
endmodule // vdi2c_slave_tb

//--- verilog/vdi2c_pkg.sv
/*
  constants, encodings and state type for the video decoder i2c slave port.
  assumes byte-wide registers reached by an 8-bit subaddress.
*/
package vdi2c_pkg;

  // ==========================================================================
  // slave address bytes
  localparam logic [7:0] ADDR_WR_DEFAULT = 8'h4A;
  localparam logic [7:0] ADDR_WR_STRAP = 8'h48;
  localparam logic [7:0] ADDR_RD_DEFAULT = 8'h4B;
  localparam logic [7:0] ADDR_RD_STRAP = 8'h49;

  // ==========================================================================
  // subaddress map
  localparam logic [7:0] SA_CHIP_VERSION = 8'h00;
  localparam logic [7:0] SA_FRONT_LO = 8'h01;
  localparam logic [7:0] SA_FRONT_HI = 8'h05;
  localparam logic [7:0] SA_DEC_LO = 8'h06;
  localparam logic [7:0] SA_DEC_HI = 8'h13;
  localparam logic [7:0] SA_DEC2_LO = 8'h15;
  localparam logic [7:0] SA_DEC2_HI = 8'h17;
  localparam logic [7:0] SA_DECODER_STATUS = 8'h1F;
  localparam logic [7:0] SA_SLICER_LO = 8'h40;
  localparam logic [7:0] SA_SLICER_HI = 8'h60;
  localparam logic [7:0] SA_SLSTAT_DR = 8'h60;
  localparam logic [7:0] SA_SLSTAT_LN1 = 8'h61;
  localparam logic [7:0] SA_SLSTAT_LN2 = 8'h62;

  // storage covers subaddresses 00h up to the last slicer setting
  localparam int REG_BYTES = 97;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_RESERVED = 8'h00;
  localparam logic [3:0] VERSION_LOW_NIBBLE = 4'h0;

  // ==========================================================================
  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] PTR_STEP = 8'h01;

  typedef enum logic [3:0] {
    VDI2C_IDLE,
    VDI2C_ADDR,
    VDI2C_ADDR_ACK,
    VDI2C_SUB,
    VDI2C_SUB_ACK,
    VDI2C_WDATA,
    VDI2C_WDATA_ACK,
    VDI2C_RDATA,
    VDI2C_RDATA_ACK
  } vdi2c_state_t;

endpackage

//--- verilog/vdi2c_regs.sv
/*
  byte register file behind the subaddress pointer, on the core clock.
  assumes status inputs come from logic on the same core clock.
*/
`timescale 1ns/100ps
module vdi2c_regs #(
  parameter logic [3:0] CHIP_VERSION = 4'h1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] slicer_status_dr,
  input wire logic [7:0] slicer_status_ln1,
  input wire logic [7:0] slicer_status_ln2,
  output logic [vdi2c_pkg::REG_BYTES*8-1:0] cfg_bytes
);
  import vdi2c_pkg::*;

  // ==========================================================================
  // writable decode
  function automatic logic writable(input logic [7:0] a);
    writable = ((a >= SA_FRONT_LO) && (a <= SA_FRONT_HI)) ||
               ((a >= SA_DEC_LO) && (a <= SA_DEC_HI)) ||
               ((a >= SA_DEC2_LO) && (a <= SA_DEC2_HI)) ||
               ((a >= SA_SLICER_LO) && (a <= SA_SLICER_HI));
  endfunction

  logic [7:0] mem_r [REG_BYTES];
  logic [7:0] mem_nxt [REG_BYTES];

  // ==========================================================================
  // storage; decoder status, version and reserved places are never stored
  always_comb begin
    for (int i = 0; i < REG_BYTES; i++) begin
      mem_nxt[i] = mem_r[i];
      if (wr_en && writable(wr_addr) && (wr_addr == 8'(i))) begin
        mem_nxt[i] = wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_BYTES; i++) begin
        mem_r[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < REG_BYTES; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  for (genvar g = 0; g < REG_BYTES; g++) begin : g_cfg
    assign cfg_bytes[g*8 +: 8] = mem_r[g];
  end

  // ==========================================================================
  // read mux; 60h reads status although its setting is still stored
  always_comb begin
    rd_data = READ_RESERVED;
    if (rd_addr == SA_CHIP_VERSION) begin
      rd_data = {CHIP_VERSION, VERSION_LOW_NIBBLE};
    end else if (rd_addr == SA_DECODER_STATUS) begin
      rd_data = status_byte;
    end else if (rd_addr == SA_SLSTAT_DR) begin
      rd_data = slicer_status_dr;
    end else if (rd_addr == SA_SLSTAT_LN1) begin
      rd_data = slicer_status_ln1;
    end else if (rd_addr == SA_SLSTAT_LN2) begin
      rd_data = slicer_status_ln2;
    end else if (writable(rd_addr)) begin
      rd_data = mem_r[rd_addr[6:0]];
    end
  end

endmodule // vdi2c_regs

//--- verilog/vdi2c_slave.sv
/*
  i2c slave control port of a video decoder: bus engine on link_clk,
  register file on core_clk, toggle handshake between them.
  assumes link_clk oversamples scl well above 400 kHz and that the pad
  resolves the open-drain sda wire from sda_oe.
*/
`timescale 1ns/100ps
module vdi2c_slave #(
  parameter logic [3:0] CHIP_VERSION = 4'h1 // arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_strap_pin,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] slicer_status_dr,
  input wire logic [7:0] slicer_status_ln1,
  input wire logic [7:0] slicer_status_ln2,
  output logic [vdi2c_pkg::REG_BYTES*8-1:0] cfg_bytes
);
  import vdi2c_pkg::*;

  // ==========================================================================
  // link-side reset: asserts at once, releases on link_clk
  logic lrst_meta_r;
  logic lrst_r;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lrst_meta_r <= 1'b1;
      lrst_r <= 1'b1;
    end else begin
      lrst_meta_r <= 1'b0;
      lrst_r <= lrst_meta_r;
    end
  end

  // ==========================================================================
  // pin sampling and bus conditions
  logic [2:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // oversampled edges keep timing independent of the bus rate
  vdi2c_sync #(.WIDTH(3)) u_pin_sync (
    .clk(link_clk),
    .rst(lrst_r),
    .d({address_strap_pin, sda_in, scl_in}),
    .q(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign strap_s = pins_s[2];

  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      scl_q_r <= 1'b0;
      sda_q_r <= 1'b0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ==========================================================================
  // own address: strap low picks the alternate pair
  logic [7:0] my_wr_addr;
  logic [7:0] my_rd_addr;

  assign my_wr_addr = strap_s ? ADDR_WR_DEFAULT : ADDR_WR_STRAP;
  assign my_rd_addr = strap_s ? ADDR_RD_DEFAULT : ADDR_RD_STRAP;

  // ==========================================================================
  // bus engine
  vdi2c_state_t state_r;
  vdi2c_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic oe_r;
  logic oe_nxt;
  logic nack_r;
  logic nack_nxt;
  logic req_tgl_r;
  logic req_tgl_nxt;
  logic req_we_r;
  logic req_we_nxt;
  logic [7:0] req_addr_r;
  logic [7:0] req_addr_nxt;
  logic [7:0] req_data_r;
  logic [7:0] req_data_nxt;
  logic [7:0] rd_link_r;
  logic [7:0] rd_link_nxt;
  logic ack_s;
  logic ack_q_r;
  logic ack_evt;
  logic [7:0] rd_core_r;
  logic ack_tgl_r;
  logic byte_end;

  assign byte_end = scl_fall && (cnt_r == BYTE_BITS);
  assign ack_evt = ack_s ^ ack_q_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    nack_nxt = nack_r;
    req_tgl_nxt = req_tgl_r;
    req_we_nxt = req_we_r;
    req_addr_nxt = req_addr_r;
    req_data_nxt = req_data_r;
    // read data is held until the core answers; every answered request lands, writes too
    rd_link_nxt = ack_evt ? rd_core_r : rd_link_r;
    if (stop_det) begin
      state_nxt = VDI2C_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      // repeated start lands here too, pointer kept
      state_nxt = VDI2C_ADDR;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        VDI2C_IDLE: begin
        end
        VDI2C_ADDR, VDI2C_SUB, VDI2C_WDATA: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_end) begin
            oe_nxt = 1'b1;
            if (state_r == VDI2C_ADDR) begin
              if (sh_r == my_rd_addr) begin
                // fetch early: the byte is due at the end of the ack
                state_nxt = VDI2C_ADDR_ACK;
                req_we_nxt = 1'b0;
                req_addr_nxt = ptr_r;
                req_tgl_nxt = ~req_tgl_r;
              end else if (sh_r == my_wr_addr) begin
                state_nxt = VDI2C_ADDR_ACK;
              end else begin
                oe_nxt = 1'b0;
                state_nxt = VDI2C_IDLE;
              end
            end else if (state_r == VDI2C_SUB) begin
              ptr_nxt = sh_r;
              state_nxt = VDI2C_SUB_ACK;
            end else begin
              req_we_nxt = 1'b1;
              req_addr_nxt = ptr_r;
              req_data_nxt = sh_r;
              req_tgl_nxt = ~req_tgl_r;
              ptr_nxt = ptr_r + PTR_STEP;
              state_nxt = VDI2C_WDATA_ACK;
            end
          end
        end
        VDI2C_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (sh_r[0]) begin
              sh_nxt = rd_link_r;
              oe_nxt = ~rd_link_r[7];
              state_nxt = VDI2C_RDATA;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = VDI2C_SUB;
            end
          end
        end
        VDI2C_SUB_ACK, VDI2C_WDATA_ACK: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            oe_nxt = 1'b0;
            state_nxt = VDI2C_WDATA;
          end
        end
        VDI2C_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_end) begin
            // release for the master's ack and fetch the next byte
            oe_nxt = 1'b0;
            ptr_nxt = ptr_r + PTR_STEP;
            req_we_nxt = 1'b0;
            req_addr_nxt = ptr_r + PTR_STEP;
            req_tgl_nxt = ~req_tgl_r;
            state_nxt = VDI2C_RDATA_ACK;
          end else if (scl_fall) begin
            oe_nxt = ~sh_r[6];
            sh_nxt = {sh_r[6:0], 1'b0};
          end
        end
        VDI2C_RDATA_ACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            cnt_nxt = '0;
            if (nack_r) begin
              // last byte refused: stay off the bus until the stop
              state_nxt = VDI2C_IDLE;
            end else begin
              sh_nxt = rd_link_r;
              oe_nxt = ~rd_link_r[7];
              state_nxt = VDI2C_RDATA;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      state_r <= VDI2C_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      ptr_r <= '0;
      oe_r <= 1'b0;
      nack_r <= 1'b0;
      req_tgl_r <= 1'b0;
      req_we_r <= 1'b0;
      req_addr_r <= '0;
      req_data_r <= '0;
      rd_link_r <= '0;
      ack_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      nack_r <= nack_nxt;
      req_tgl_r <= req_tgl_nxt;
      req_we_r <= req_we_nxt;
      req_addr_r <= req_addr_nxt;
      req_data_r <= req_data_nxt;
      rd_link_r <= rd_link_nxt;
      ack_q_r <= ack_s;
    end
  end

  // open drain: only ever pulls low
  assign sda_oe = oe_r;
  assign sda_out = 1'b0;

  // ==========================================================================
  // core side of the handshake; request fields are stable while pending
  logic req_s;
  logic req_q_r;
  logic req_evt;
  logic [7:0] rd_data;
  logic [7:0] rd_core_nxt;
  logic ack_tgl_nxt;

  vdi2c_sync #(.WIDTH(1)) u_req_sync (
    .clk(core_clk),
    .rst(rst),
    .d(req_tgl_r),
    .q(req_s)
  );

  vdi2c_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .rst(lrst_r),
    .d(ack_tgl_r),
    .q(ack_s)
  );

  assign req_evt = req_s ^ req_q_r;

  always_comb begin
    rd_core_nxt = rd_core_r;
    ack_tgl_nxt = ack_tgl_r;
    if (req_evt) begin
      rd_core_nxt = rd_data;
      ack_tgl_nxt = ~ack_tgl_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_q_r <= 1'b0;
      rd_core_r <= '0;
      ack_tgl_r <= 1'b0;
    end else begin
      req_q_r <= req_s;
      rd_core_r <= rd_core_nxt;
      ack_tgl_r <= ack_tgl_nxt;
    end
  end

  vdi2c_regs #(.CHIP_VERSION(CHIP_VERSION)) u_regs (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(req_evt & req_we_r),
    .wr_addr(req_addr_r),
    .wr_data(req_data_r),
    .rd_addr(req_addr_r),
    .rd_data(rd_data),
    .status_byte(status_byte),
    .slicer_status_dr(slicer_status_dr),
    .slicer_status_ln1(slicer_status_ln1),
    .slicer_status_ln2(slicer_status_ln2),
    .cfg_bytes(cfg_bytes)
  );

endmodule // vdi2c_slave

//--- verilog/vdi2c_sync.sv
/*
  two-flop synchroniser of parameterised width.
  assumes each bit is an independent level; no word coherence across bits.
*/
`timescale 1ns/100ps
module vdi2c_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ==========================================================================
  // stages
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end

endmodule // vdi2c_sync
